// ### rtl/trcd_defs.svh
// Purpose: constants for the terminal run command decoder
// Assumes: 40 MHz system clock
// Notes: every offset, default and timing count lives here
//
// Contract
// RULE_01 - Mode selector picks six behaviours, default zero
// RULE_02 - Two-wire 1: function 1 forward, 2 reverse
// RULE_03 - Two-wire 1: both active keeps first direction
// RULE_04 - Two-wire 2: function 1 enables, 2 selects direction
// RULE_05 - Three-wire 1: enable first, edges start directions
// RULE_06 - Three-wire modes stop when enable opens
// RULE_07 - Three-wire 2: run edge starts, direction follows level
// RULE_08 - Three-wire 2: only run input edge sensitive
// RULE_09 - Three-wire 1, alternate: edges for fwd/rev, enable level
// RULE_10 - Alternate: edges toggle start and stop
// RULE_11 - Alternate: opening enable always stops
// RULE_12 - Back-and-forth: enable runs remembered direction, forward first
// RULE_13 - Back-and-forth: edge reverses after minimum interval
// RULE_14 - Command roles only on base and pulse inputs
// RULE_15 - Function selectors 0..63 with given defaults
// RULE_16 - Function 0 input is ignored
// RULE_17 - Function 3 is the three-wire enable
// RULE_18 - Function 4 requests forward jog
// RULE_19 - Expansion card adds three inputs
// RULE_20 - Function 6 blocks output, coast stop
// RULE_21 - Function 7 pauses and later resumes
// RULE_22 - Function 8 clears fault like keypad
// RULE_23 - Function 9 raises external fault alarm
// RULE_24 - Inputs synchronised and debounced before use
`ifndef TRCD_DEFS_SVH
`define TRCD_DEFS_SVH

`define TRCD_N_TERM 9
`define TRCD_N_CMD_TERM 6
`define TRCD_FSEL_W 6
`define TRCD_MODE_RST 3'h0

`define TRCD_FN_NONE 6'h00
`define TRCD_FN_FWD 6'h01
`define TRCD_FN_REV 6'h02
`define TRCD_FN_ENABLE 6'h03
`define TRCD_FN_JOG_FWD 6'h04
`define TRCD_FN_JOG_REV 6'h05
`define TRCD_FN_COAST 6'h06
`define TRCD_FN_PAUSE 6'h07
`define TRCD_FN_FAULT_RST 6'h08
`define TRCD_FN_EXT_FAULT 6'h09

`define TRCD_FSEL1_RST 6'h01
`define TRCD_FSEL2_RST 6'h02
`define TRCD_FSEL3_RST 6'h04
`define TRCD_FSEL4_RST 6'h06
`define TRCD_FSEL5_RST 6'h08
`define TRCD_FSEL_PULSE_RST 6'h00
`define TRCD_FSEL_EXP_RST 6'h00
`define TRCD_INTERVAL_RST 16'h0000

`define TRCD_CLK_PERIOD_NS 25
`define TRCD_DEB_TIME_NS 5000000
`define TRCD_DEB_CYCLES (`TRCD_DEB_TIME_NS / `TRCD_CLK_PERIOD_NS)
`define TRCD_MS_NS 1000000
`define TRCD_MS_CYCLES (`TRCD_MS_NS / `TRCD_CLK_PERIOD_NS)
`define TRCD_DEB_CNT_W 18
`define TRCD_MS_CNT_W 16

`endif

// ### rtl/trcd_pkg.sv
// Purpose: types for the terminal run command decoder
// Assumes: nothing
// Notes: mode encoding follows enum order
package trcd_pkg;
	typedef enum logic [2:0] {
		TWO_WIRE_1,
		TWO_WIRE_2,
		THREE_WIRE_1,
		THREE_WIRE_2,
		ALTERNATE,
		BACK_FORTH
	} trcd_mode_t;
endpackage

// ### rtl/trcd_term_if.sv
// Purpose: carries debounced terminal levels and rising edges
// Assumes: single clock
// Notes: rise is a one-cycle pulse aligned with level going high
`timescale 1ns/100ps
interface trcd_term_if;
	logic [8:0] level;
	logic [8:0] rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// ### rtl/trcd_debounce.sv
// Purpose: synchronise and debounce the terminal inputs
// Assumes: raw inputs are asynchronous contacts
// Notes: a level is accepted once stable for DEB_CYCLES cycles
`timescale 1ns/100ps
`include "trcd_defs.svh"
module trcd_debounce #(
	parameter int DEB_CYCLES = `TRCD_DEB_CYCLES
) (
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Synchronised reset
	input wire logic [8:0] raw, // Terminal pins
	trcd_term_if.src term // Clean levels and edges
);
	genvar i;
	generate
		for (i = 0; i < `TRCD_N_TERM; i++) begin : g_ch
			logic meta;
			logic sync;
			logic stable;
			logic edge_q;
			logic [`TRCD_DEB_CNT_W-1:0] cnt;
			wire differs = sync != stable;
			wire settled = cnt == `TRCD_DEB_CNT_W'(DEB_CYCLES - 1);
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					meta <= 1'b0;
					sync <= 1'b0;
					stable <= 1'b0;
					edge_q <= 1'b0;
					cnt <= '0;
				end else begin
					meta <= raw[i]; // [RULE_24]
					sync <= meta;
					edge_q <= differs && settled && sync; // [RULE_24]
					if (!differs) begin
						cnt <= '0;
					end else if (settled) begin
						stable <= sync;
						cnt <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
			end
			assign term.level[i] = stable;
			assign term.rise[i] = edge_q;
		end
	endgenerate
endmodule

// ### rtl/trcd_top.sv
// Purpose: decode terminal inputs into run, stop and direction commands
// Assumes: configuration ports driven from logic on sys_clk
// Notes: configuration is captured on cfg_load; defaults apply after reset
`timescale 1ns/100ps
`include "trcd_defs.svh"
module trcd_top #(
	parameter int DEB_CYCLES = `TRCD_DEB_CYCLES,
	parameter int MS_CYCLES = `TRCD_MS_CYCLES
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [4:0] base_digital_inputs, // Base terminal pins
	input wire logic high_speed_pulse_input, // Pulse-capable pin
	input wire logic [2:0] expansion_digital_inputs, // Expansion pins
	input wire logic expansion_card_present, // Card fitted pin
	input wire logic cfg_load, // Capture configuration
	input wire logic [2:0] terminal_command_mode_sel, // Command mode
	input wire logic [5:0] input1_function_sel, // Base input 1 role
	input wire logic [5:0] input2_function_sel, // Base input 2 role
	input wire logic [5:0] input3_function_sel, // Base input 3 role
	input wire logic [5:0] input4_function_sel, // Base input 4 role
	input wire logic [5:0] input5_function_sel, // Base input 5 role
	input wire logic [5:0] pulse_input_function_sel, // Pulse input role
	input wire logic [17:0] expansion_function_sel, // Three 6-bit roles
	input wire logic [15:0] reversal_min_interval, // Milliseconds
	input wire logic keypad_fault_reset, // Keypad reset pulse
	output logic run_cmd, // Drive runs
	output logic run_reverse, // Direction, high is reverse
	output logic jog_forward, // Forward jog request
	output logic jog_reverse, // Reverse jog request
	output logic output_block, // Coast, output blocked
	output logic pause_active, // Run pause in force
	output logic fault_clear, // Fault reset pulse
	output logic ext_fault_alarm // External fault latched
);
	////////////////////////////////////////////////////////////////////
	// Reset leaves through two flops so every register releases on one edge
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Card detect is an asynchronous pin like the terminals
	logic card_meta;
	logic card_ok;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			card_meta <= 1'b0;
			card_ok <= 1'b0;
		end else begin
			card_meta <= expansion_card_present;
			card_ok <= card_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	trcd_pkg::trcd_mode_t mode;
	logic [8:0][5:0] fsel;
	logic [15:0] min_interval;
	// A constant, so the asynchronous reset branch loads no logic
	localparam logic [8:0][5:0] fsel_rst = {{3{`TRCD_FSEL_EXP_RST}}, `TRCD_FSEL_PULSE_RST,
		`TRCD_FSEL5_RST, `TRCD_FSEL4_RST, `TRCD_FSEL3_RST, `TRCD_FSEL2_RST,
		`TRCD_FSEL1_RST};
	wire [8:0][5:0] fsel_in = {expansion_function_sel, pulse_input_function_sel,
		input5_function_sel, input4_function_sel, input3_function_sel,
		input2_function_sel, input1_function_sel};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= trcd_pkg::trcd_mode_t'(`TRCD_MODE_RST); // [RULE_01]
			min_interval <= `TRCD_INTERVAL_RST;
		end else if (cfg_load) begin
			mode <= trcd_pkg::trcd_mode_t'(terminal_command_mode_sel);
			min_interval <= reversal_min_interval;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fsel <= fsel_rst; // [RULE_15]
		end else if (cfg_load) begin
			fsel <= fsel_in; // [RULE_15]
		end
	end

	////////////////////////////////////////////////////////////////////
	trcd_term_if term ();

	trcd_debounce #(
		.DEB_CYCLES(DEB_CYCLES)
	) u_deb (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raw({expansion_digital_inputs, high_speed_pulse_input, base_digital_inputs}),
		.term(term)
	); // [RULE_24]

	// Command roles only from the six on-board terminals
	wire [8:0] cmd_mask = {3'h0, 6'h3F}; // [RULE_14]
	// Expansion terminals count only while the card is fitted
	wire [8:0] any_mask = {{3{card_ok}}, 6'h3F}; // [RULE_19]

	function automatic logic fn_hit(input logic [8:0] v, input logic [8:0][5:0] sel,
		input logic [8:0] mask, input logic [5:0] code);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < `TRCD_N_TERM; k++) begin
			// Code 0 never matches a real role, so unused inputs stay inert
			if (mask[k] && sel[k] == code && code != `TRCD_FN_NONE) begin // [RULE_16]
				hit = hit | v[k];
			end
		end
		return hit;
	endfunction

	// Each role is the OR of every enabled terminal that carries it
	wire fwd_lv = fn_hit(term.level, fsel, cmd_mask, `TRCD_FN_FWD);
	wire rev_lv = fn_hit(term.level, fsel, cmd_mask, `TRCD_FN_REV);
	wire en_lv = fn_hit(term.level, fsel, cmd_mask, `TRCD_FN_ENABLE); // [RULE_17]
	wire fwd_rise = fn_hit(term.rise, fsel, cmd_mask, `TRCD_FN_FWD);
	wire rev_rise = fn_hit(term.rise, fsel, cmd_mask, `TRCD_FN_REV);
	wire jogf_lv = fn_hit(term.level, fsel, any_mask, `TRCD_FN_JOG_FWD);
	wire jogr_lv = fn_hit(term.level, fsel, any_mask, `TRCD_FN_JOG_REV);
	wire coast_lv = fn_hit(term.level, fsel, any_mask, `TRCD_FN_COAST);
	wire pause_lv = fn_hit(term.level, fsel, any_mask, `TRCD_FN_PAUSE);
	wire frst_rise = fn_hit(term.rise, fsel, any_mask, `TRCD_FN_FAULT_RST);
	wire xflt_rise = fn_hit(term.rise, fsel, any_mask, `TRCD_FN_EXT_FAULT);
	wire any_rise = fwd_rise | rev_rise;

	////////////////////////////////////////////////////////////////////
	// Millisecond timebase and time since last reversal
	logic [`TRCD_MS_CNT_W-1:0] ms_div;
	logic [15:0] since_rev;
	wire ms_tick = ms_div == `TRCD_MS_CNT_W'(MS_CYCLES - 1);
	wire rev_allowed = since_rev > min_interval; // [RULE_13]

	logic run;
	logic dir;
	logic next_run;
	logic next_dir;
	logic do_reverse;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_div <= '0;
		end else begin
			ms_div <= ms_tick ? '0 : ms_div + 1'b1;
		end
	end

	// Starts saturated so the first reversal after reset is held off only when min_interval is 16'hFFFF
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_rev <= 16'hFFFF;
		end else if (do_reverse) begin
			since_rev <= 16'h0000; // [RULE_13]
		end else if (ms_tick && since_rev != 16'hFFFF) begin
			since_rev <= since_rev + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_run = run;
		next_dir = dir;
		do_reverse = 1'b0;
		unique case (mode)
			trcd_pkg::TWO_WIRE_1: begin
				next_run = fwd_lv | rev_lv; // [RULE_02]
				if (fwd_lv && !rev_lv) begin
					next_dir = 1'b0; // [RULE_02]
				end else if (rev_lv && !fwd_lv) begin
					next_dir = 1'b1;
				end else if (fwd_lv && rev_lv && !run) begin
					// Both arriving together from stop: forward wins
					next_dir = fwd_rise ? 1'b0 : dir; // [RULE_03]
				end
			end
			trcd_pkg::TWO_WIRE_2: begin
				next_run = fwd_lv; // [RULE_04]
				next_dir = rev_lv; // [RULE_04]
			end
			trcd_pkg::THREE_WIRE_1: begin
				if (!en_lv) begin
					next_run = 1'b0; // [RULE_06]
				end else if (fwd_rise) begin
					next_run = 1'b1; // [RULE_05] [RULE_09]
					next_dir = 1'b0;
				end else if (rev_rise) begin
					next_run = 1'b1; // [RULE_05] [RULE_09]
					next_dir = 1'b1;
				end
			end
			trcd_pkg::THREE_WIRE_2: begin
				next_dir = rev_lv; // [RULE_07] [RULE_08]
				if (!en_lv) begin
					next_run = 1'b0; // [RULE_06]
				end else if (fwd_rise) begin
					next_run = 1'b1; // [RULE_07] [RULE_08]
				end
			end
			trcd_pkg::ALTERNATE: begin
				if (!en_lv) begin
					next_run = 1'b0; // [RULE_11]
				end else if (any_rise) begin
					next_run = !run; // [RULE_10] [RULE_09]
					if (!run) begin
						next_dir = !fwd_rise; // [RULE_10]
					end
				end
			end
			trcd_pkg::BACK_FORTH: begin
				next_run = en_lv; // [RULE_12]
				if (en_lv && run && any_rise && rev_allowed) begin
					do_reverse = 1'b1;
					next_dir = !dir; // [RULE_13]
				end
			end
			default: begin
				next_run = 1'b0;
			end
		endcase
		// A coast stop drops the latched run so it does not resume by itself in the three-wire and alternate modes
		if (coast_lv) begin
			next_run = 1'b0; // [RULE_20]
		end
	end

	// Direction resets to forward, giving the first back-and-forth run
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= 1'b0;
			dir <= 1'b0; // [RULE_12]
		end else begin
			run <= next_run;
			dir <= next_dir;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pause masks the command only; run and dir keep evolving and resume
	wire next_run_cmd = run && !pause_lv && !coast_lv; // [RULE_21]
	wire next_fault_clear = frst_rise | keypad_fault_reset; // [RULE_22]

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_cmd <= 1'b0;
			run_reverse <= 1'b0;
		end else begin
			run_cmd <= next_run_cmd; // [RULE_21]
			run_reverse <= dir;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_forward <= 1'b0;
			jog_reverse <= 1'b0;
		end else begin
			jog_forward <= jogf_lv; // [RULE_18]
			jog_reverse <= jogr_lv;
		end
	end

	// Block and pause stay separate levels so the drive side can tell them apart
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			output_block <= 1'b0;
			pause_active <= 1'b0;
		end else begin
			output_block <= coast_lv; // [RULE_20]
			pause_active <= pause_lv; // [RULE_21]
		end
	end

	// Clear pulse shared by the keypad and the terminal role; it lasts as long as the keypad input is held
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_clear <= 1'b0;
		end else begin
			fault_clear <= next_fault_clear; // [RULE_22]
		end
	end

	// Set wins over clear so a fault arriving with a reset is not lost
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_fault_alarm <= 1'b0;
		end else if (xflt_rise) begin
			ext_fault_alarm <= 1'b1; // [RULE_23]
		end else if (next_fault_clear) begin
			ext_fault_alarm <= 1'b0; // [RULE_22]
		end
	end
endmodule

// ### sim/trcd_checker.sv
// Purpose: port-level temporal checks for the run command decoder
// Assumes: one clock domain, bound to the top module
// Notes: reversal spacing is judged in whole clock cycles
`timescale 1ns/100ps
module trcd_checker #(
	parameter int DEB_CYCLES = 4,
	parameter int MS_CYCLES = 10
) (
	input wire logic sys_clk, // Clock
	input wire logic arst_n, // Reset, active low
	input wire logic cfg_load, // Config strobe
	input wire logic [2:0] terminal_command_mode_sel, // Mode
	input wire logic [15:0] reversal_min_interval, // Milliseconds
	input wire logic keypad_fault_reset, // Keypad reset
	input wire logic run_cmd, // Run
	input wire logic run_reverse, // Direction
	input wire logic output_block, // Coast
	input wire logic pause_active, // Pause
	input wire logic fault_clear, // Fault reset pulse
	input wire logic ext_fault_alarm // Alarm
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!arst_n);
logic [2:0] mode;
logic [15:0] ival;
logic rev_q;
int gap;
wire rev_turn = run_reverse != rev_q;
// Shadow of the configuration, captured on the same strobe as the design
always_ff @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		mode <= 3'h0;
		ival <= 16'h0000;
	end else if (cfg_load) begin
		mode <= terminal_command_mode_sel;
		ival <= reversal_min_interval;
	end
end
// Starts saturated so the first reversal is held back only when ival * MS_CYCLES reaches 1000000
always_ff @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		rev_q <= 1'b0;
		gap <= 1000000;
	end else begin
		rev_q <= run_reverse;
		gap <= rev_turn ? 1 : (gap < 1000000 ? gap + 1 : gap);
	end
end
sequence s_bad_load;
	cfg_load && terminal_command_mode_sel > 3'h5 ##1 !cfg_load [*4];
endsequence
sequence s_paused;
	pause_active ##1 pause_active;
endsequence
sequence s_two_clears;
	fault_clear ##1 fault_clear;
endsequence
chk_reset_quiet: assert property ($rose(arst_n) |-> (!run_cmd && !output_block && !ext_fault_alarm) [*2])
	else $error("outputs active right after reset");
chk_bad_mode: assert property (s_bad_load |-> !run_cmd)
	else $error("run with unused mode code");
chk_block_stop: assert property (output_block |=> !run_cmd)
	else $error("run while output blocked");
chk_pause_mask: assert property (s_paused |-> !run_cmd)
	else $error("run while paused");
chk_keypad_clear: assert property (keypad_fault_reset |=> fault_clear)
	else $error("keypad reset gave no clear pulse");
chk_clear_pair: assert property (s_two_clears |-> $past(keypad_fault_reset) || $past(keypad_fault_reset, 2))
	else $error("clear pulse stretched");
chk_alarm_drop: assert property ($fell(ext_fault_alarm) |-> fault_clear)
	else $error("alarm dropped without clear");
chk_reverse_gap: assert property (mode == 3'h5 && run_cmd && $past(run_cmd) && rev_turn |-> gap > ival * MS_CYCLES)
	else $error("reversal too soon");
endmodule
bind trcd_top trcd_checker #(.DEB_CYCLES(DEB_CYCLES), .MS_CYCLES(MS_CYCLES)) trcd_checker_inst (.*);

// ### sim/trcd_switches.sv
// Purpose: contacts and buttons wired to the terminals
// Assumes: press changes at a falling edge
// Notes: every change bounces for two cycles, shorter than the filter
`timescale 1ns/100ps
module trcd_switches (
	input wire logic sys_clk, // Clock
	input wire logic [8:0] press, // Contacts held closed
	output logic [4:0] base_pins, // Base terminals
	output logic pulse_pin, // Pulse-capable terminal
	output logic [2:0] exp_pins // Expansion terminals
);
logic [8:0] held = 9'h000;
logic [8:0] chg = 9'h000;
logic [8:0] pins = 9'h000;
int bounce = 0;
int seed = 29;
assign base_pins = pins[4:0];
assign pulse_pin = pins[5];
assign exp_pins = pins[8:6];
always @(negedge sys_clk) begin
	if (press !== held) begin
		chg = press ^ held;
		held = press;
		bounce = 2;
	end
	if (bounce > 0) begin
		pins = (held & ~chg) | (9'($random(seed)) & chg);
		bounce = bounce - 1;
	end else begin
		pins = held;
	end
end
endmodule

// ### sim/trcd_top_test.sv
// Purpose: self-checking bench for the run command decoder
// Assumes: short debounce and millisecond counts
// Notes: stopped direction is not compared
`timescale 1ns/100ps
module trcd_top_test;
typedef struct {logic [6:0] lv; int pulses;} trcd_note_t;
localparam logic [35:0] ROLES_B = {6'h01, 6'h02, 6'h03, 6'h07, 6'h09, 6'h00};
localparam logic [35:0] ROLES_C = {6'h00, 6'h02, 6'h03, 6'h07, 6'h09, 6'h01};
logic sys_clk = 1'b0;
logic arst_n = 1'b0;
logic [8:0] press = 9'h000;
logic [4:0] base;
logic hdi;
logic [2:0] expi;
logic card = 1'b0;
logic cfg_load = 1'b0;
logic [2:0] mode = 3'h0;
logic [35:0] roles = 36'h0;
logic [17:0] exp_sel = 18'h00000;
logic [15:0] ival = 16'h0000;
logic kp = 1'b0;
logic run_cmd, run_reverse, jog_forward, jog_reverse;
logic output_block, pause_active, fault_clear, ext_fault_alarm;
int fail_count = 0;
int checks = 0;
int pulses = 0;
int exp_pulses = 0;
trcd_note_t notes[$];
trcd_note_t note;
event settled;
trcd_top #(.DEB_CYCLES(4), .MS_CYCLES(10)) trcd_top_inst (.sys_clk(sys_clk), .arst_n(arst_n),
	.base_digital_inputs(base), .high_speed_pulse_input(hdi), .expansion_digital_inputs(expi),
	.expansion_card_present(card), .cfg_load(cfg_load), .terminal_command_mode_sel(mode),
	.input1_function_sel(roles[35:30]), .input2_function_sel(roles[29:24]),
	.input3_function_sel(roles[23:18]), .input4_function_sel(roles[17:12]),
	.input5_function_sel(roles[11:6]), .pulse_input_function_sel(roles[5:0]),
	.expansion_function_sel(exp_sel), .reversal_min_interval(ival), .keypad_fault_reset(kp),
	.run_cmd(run_cmd), .run_reverse(run_reverse), .jog_forward(jog_forward),
	.jog_reverse(jog_reverse), .output_block(output_block), .pause_active(pause_active),
	.fault_clear(fault_clear), .ext_fault_alarm(ext_fault_alarm));
trcd_switches trcd_switches_inst (.sys_clk(sys_clk), .press(press), .base_pins(base),
	.pulse_pin(hdi), .exp_pins(expi));
always #12.5 sys_clk = ~sys_clk;
always @(posedge sys_clk) if (fault_clear === 1'b1) pulses = pulses + 1;
task automatic print_verdict;
	$display("checks %0d, mismatches %0d", checks, fail_count);
	if (fail_count == 0 && checks > 0) begin
		$display("SIMULATION PASSED");
	end else begin
		$display("SIMULATION FAILED");
	end
	$finish;
endtask
task automatic report(input logic bad, input string what);
	checks = checks + 1;
	if (bad) begin
		fail_count = fail_count + 1;
		$display("unexpected at %0t: %s", $time, what);
	end
endtask
task automatic cmp_levels(input logic [6:0] e);
	logic [6:0] g;
	logic [6:0] m;
	g = {run_cmd, run_reverse, jog_forward, jog_reverse, output_block, pause_active, ext_fault_alarm};
	m = e[6] ? 7'h7F : 7'h5F;
	report((g & m) !== (e & m), $sformatf("outputs %h, wanted %h", g, e));
endtask
task automatic cmp_pulse(input int e);
	report(pulses != e, $sformatf("%0d clear pulses, wanted %0d", pulses, e));
endtask
task automatic cfg(input logic [2:0] m, input logic [35:0] r, input logic [15:0] iv);
	@(negedge sys_clk);
	mode = m;
	roles = r;
	exp_sel = 18'h05046;
	ival = iv;
	cfg_load = 1'b1;
	@(negedge sys_clk);
	cfg_load = 1'b0;
endtask
// Each step waits past the filter and decode latency before noting the result
task automatic step(input logic [8:0] p, input logic [6:0] lv, input int inc = 0);
	@(negedge sys_clk);
	press <= p;
	repeat (18) @(negedge sys_clk);
	exp_pulses = exp_pulses + inc;
	notes.push_back('{lv, exp_pulses});
	-> settled;
endtask
task automatic kpush(input int n);
	@(negedge sys_clk);
	kp = 1'b1;
	repeat (n) @(negedge sys_clk);
	kp = 1'b0;
endtask
initial forever begin
	@(settled);
	note = notes.pop_front();
	cmp_levels(note.lv);
	cmp_pulse(note.pulses);
end
initial begin
	repeat (4000) @(posedge sys_clk);
	fail_count = fail_count + 1;
	print_verdict();
end
initial begin
	repeat (4) @(negedge sys_clk);
	arst_n = 1'b1;
	repeat (3) @(negedge sys_clk);
	step(9'h001, 7'h40);
	step(9'h003, 7'h40);
	step(9'h002, 7'h60);
	step(9'h004, 7'h10);
	step(9'h009, 7'h04);
	step(9'h010, 7'h00, 1);
	$display("test defaults done");
	cfg(3'h1, ROLES_B, 16'h0000);
	step(9'h001, 7'h40);
	step(9'h003, 7'h60);
	step(9'h002, 7'h00);
	$display("test two-wire 2 done");
	cfg(3'h2, ROLES_B, 16'h0000);
	step(9'h001, 7'h00);
	step(9'h004, 7'h00);
	step(9'h005, 7'h40);
	step(9'h004, 7'h40);
	step(9'h006, 7'h60);
	step(9'h002, 7'h00);
	$display("test three-wire 1 done");
	cfg(3'h3, ROLES_B, 16'h0000);
	step(9'h006, 7'h00);
	step(9'h007, 7'h60);
	step(9'h005, 7'h40);
	step(9'h001, 7'h00);
	$display("test three-wire 2 done");
	cfg(3'h4, ROLES_B, 16'h0000);
	step(9'h004, 7'h00);
	step(9'h006, 7'h60);
	step(9'h004, 7'h60);
	step(9'h005, 7'h00);
	step(9'h004, 7'h00);
	step(9'h005, 7'h40);
	step(9'h001, 7'h00);
	$display("test alternate done");
	cfg(3'h5, ROLES_B, 16'h0002);
	step(9'h004, 7'h40);
	repeat (30) @(negedge sys_clk);
	step(9'h005, 7'h60);
	step(9'h007, 7'h60);
	step(9'h004, 7'h60);
	step(9'h005, 7'h40);
	step(9'h00D, 7'h02);
	step(9'h005, 7'h40);
	step(9'h010, 7'h01);
	step(9'h000, 7'h01);
	kpush(2);
	step(9'h000, 7'h00, 2);
	$display("test back-and-forth done");
	cfg(3'h0, ROLES_C, 16'h0000);
	step(9'h020, 7'h40);
	step(9'h040, 7'h00);
	card = 1'b1;
	step(9'h040, 7'h04);
	step(9'h080, 7'h00);
	step(9'h100, 7'h08);
	step(9'h001, 7'h00);
	step(9'h020, 7'h40);
	cfg(3'h6, ROLES_C, 16'h0000);
	step(9'h020, 7'h00);
	$display("test roles and terminals done");
	@(negedge sys_clk);
	print_verdict();
end
endmodule
